// file: hdl/sps_pkg.sv
package sps_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [31:0] SPS_CTRL_OFFSET = 32'hF100_0550;

  // field positions in lsb-0 numbering (msb is documented bit 0)
  localparam int SPS_POS_PRESENT  = 31;
  localparam int SPS_POS_ERROR    = 30;
  localparam int SPS_POS_BUSY     = 24;
  localparam int SPS_POS_SAVE     = 23;
  localparam int SPS_POS_RESTORE  = 22;
  localparam int SPS_POS_SETDEF   = 21;
  localparam int SPS_POS_FAULT_LO = 8;
  localparam int SPS_POS_SLOT_LO  = 0;
  localparam int SPS_FIELD_W      = 4;

  // ------------------------------------------------------------
  // sizes and reset values
  // ------------------------------------------------------------
  localparam int SPS_NUM_SLOTS  = 4;
  localparam int SPS_NUM_WORDS  = 16;
  localparam int SPS_DATA_W     = 32;
  localparam int SPS_CFG_AW     = 8;
  localparam logic [3:0] SPS_FACTORY_SLOT = 4'h0;
  localparam logic [3:0] SPS_RST_DEF_SLOT = 4'h0;

  // ------------------------------------------------------------
  // fault reasons
  // ------------------------------------------------------------
  localparam logic [3:0] SPS_F_NONE      = 4'h0;
  localparam logic [3:0] SPS_F_CORRUPT   = 4'h1;
  localparam logic [3:0] SPS_F_NOT_IDLE  = 4'h2;
  localparam logic [3:0] SPS_F_ABSENT    = 4'h3;
  localparam logic [3:0] SPS_F_NO_SLOT   = 4'h4;
  localparam logic [3:0] SPS_F_RANGE     = 4'h5;
  localparam logic [3:0] SPS_F_DEF_FAIL  = 4'h6;
  localparam logic [3:0] SPS_F_LUT_LOAD  = 4'h7;
  localparam logic [3:0] SPS_F_LUT_STORE = 4'h8;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } sps_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] rdata;
  } sps_resp_t;

  typedef struct packed {
    logic                  wr;
    logic [SPS_CFG_AW-1:0] addr;
    logic [31:0]           wdata;
  } sps_cfg_t;

  typedef enum logic [2:0] {
    SPS_BOOT, SPS_IDLE, SPS_SAVE, SPS_VER_A, SPS_VER_D,
    SPS_APP_A, SPS_APP_D, SPS_APP_W
  } sps_state_t;

endpackage

// file: hdl/sps_walker.sv
`timescale 1ns/10ps
`default_nettype none
module sps_walker #(
  parameter int COUNT = 17
) (
  input  wire logic                     clk,
  input  wire logic                     rstn,
  input  wire logic                     clear,
  input  wire logic                     step,
  output logic      [$clog2(COUNT)-1:0] idx,
  output logic                          last
);
  import sps_pkg::*;

  typedef struct packed {
    logic [$clog2(COUNT)-1:0] idx;
  } sps_walk_st_t;

  sps_walk_st_t r;
  sps_walk_st_t next_r;

  always_comb begin
    next_r = r;
    if (clear) begin
      next_r.idx = '0;
    end else if (step && !last) begin
      next_r.idx = r.idx + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign idx  = r.idx;
  assign last = (r.idx == ($clog2(COUNT))'(COUNT - 1));
endmodule // sps_walker
`default_nettype wire

// file: hdl/sps_slot_mem.sv
`timescale 1ns/10ps
`default_nettype none
module sps_slot_mem #(
  parameter int SLOTS = 4,
  parameter int WORDS = 17,
  parameter int WIDTH = 32
) (
  input  wire logic                     clk,
  input  wire logic                     wr_en,
  input  wire logic [3:0]               wr_slot,
  input  wire logic [$clog2(WORDS)-1:0] wr_idx,
  input  wire logic [WIDTH-1:0]         wdata,
  input  wire logic [3:0]               rd_slot,
  input  wire logic [$clog2(WORDS)-1:0] rd_idx,
  output logic      [WIDTH-1:0]         rdata
);
  import sps_pkg::*;

  localparam int AW = $clog2(SLOTS * WORDS);

  logic [WIDTH-1:0] mem [SLOTS*WORDS];

  // ------------------------------------------------------------
  // factory slot is a fixed pattern, never stored
  // ------------------------------------------------------------
  function automatic logic [WIDTH-1:0] factory_word(
    input logic [$clog2(WORDS)-1:0] i);
    factory_word = WIDTH'(i);
  endfunction

  function automatic logic [AW-1:0] word_addr(
    input logic [3:0] s, input logic [$clog2(WORDS)-1:0] i);
    word_addr = AW'(s * WORDS + i);
  endfunction

  always_ff @(posedge clk) begin
    if (wr_en && wr_slot != SPS_FACTORY_SLOT) begin
      mem[word_addr(wr_slot, wr_idx)] <= wdata;
    end
    if (rd_slot == SPS_FACTORY_SLOT) begin
      rdata <= factory_word(rd_idx);
    end else begin
      rdata <= mem[word_addr(rd_slot, rd_idx)];
    end
  end
endmodule // sps_slot_mem
`default_nettype wire

// file: hdl/sps_profile_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module sps_profile_ctrl #(
  parameter int   NUM_SLOTS = sps_pkg::SPS_NUM_SLOTS,
  parameter int   NUM_WORDS = sps_pkg::SPS_NUM_WORDS,
  parameter logic PRESENT   = 1'b1
) (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire sps_pkg::sps_req_t  req,
  output logic                    req_ready,
  output sps_pkg::sps_resp_t      resp,
  output sps_pkg::sps_cfg_t       cfg,
  input  wire logic [31:0]        cfg_rdata,
  input  wire logic               init_command,
  input  wire logic               camera_idle,
  input  wire logic               lut_fault,
  output logic                    capture_off,
  output logic                    factory_all,
  output logic                    busy
);
  import sps_pkg::*;

  localparam int STEPS = NUM_WORDS + 1;
  localparam int IW    = $clog2(STEPS);

  typedef struct packed {
    sps_state_t  st;
    logic        boot;
    logic [3:0]  slot;
    logic [3:0]  fault;
    logic [3:0]  def_slot;
    logic [3:0]  src_slot;
    logic [15:0] slot_ok;
    logic [31:0] acc;
    logic        ready;
    sps_resp_t   resp;
    sps_cfg_t    cfg;
    logic        capture_off;
    logic        factory_all;
    logic        busy;
  } sps_ctrl_st_t;

  sps_ctrl_st_t r;
  sps_ctrl_st_t next_r;

  logic          w_clear;
  logic          w_step;
  logic [IW-1:0] w_idx;
  logic          w_last;
  logic          m_wr;
  logic [31:0]   m_wdata;
  logic [31:0]   m_rdata;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  logic        hit;
  logic        acc_wr;
  logic        acc_rd;
  logic [3:0]  w_slot;
  logic        f_save;
  logic        f_rest;
  logic        f_def;
  logic        in_range;
  logic [31:0] ctrl_word;

  assign hit      = req.valid && r.ready && req.addr == SPS_CTRL_OFFSET;
  assign acc_wr   = hit && req.write;
  assign acc_rd   = hit && !req.write;
  assign w_slot   = req.wdata[SPS_POS_SLOT_LO +: SPS_FIELD_W];
  assign f_save   = req.wdata[SPS_POS_SAVE];
  assign f_rest   = req.wdata[SPS_POS_RESTORE];
  assign f_def    = req.wdata[SPS_POS_SETDEF];
  assign in_range = 32'(w_slot) < NUM_SLOTS;

  always_comb begin
    ctrl_word                                   = '0;
    ctrl_word[SPS_POS_PRESENT]                  = PRESENT;
    ctrl_word[SPS_POS_ERROR]                    = r.fault != SPS_F_NONE;
    ctrl_word[SPS_POS_BUSY]                     = r.busy;
    ctrl_word[SPS_POS_FAULT_LO +: SPS_FIELD_W]  = r.fault;
    ctrl_word[SPS_POS_SLOT_LO +: SPS_FIELD_W]   = r.slot;
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_r             = r;
    next_r.resp.valid  = 1'b0;
    next_r.cfg.wr      = 1'b0;
    next_r.capture_off = 1'b0;
    next_r.factory_all = 1'b0;
    w_clear            = 1'b0;
    w_step             = 1'b0;
    m_wr               = 1'b0;
    m_wdata            = cfg_rdata;
    case (r.st)
      SPS_BOOT: begin
        next_r.boot     = 1'b1;
        next_r.src_slot = r.def_slot;
        next_r.slot     = r.def_slot;
        next_r.acc      = '0;
        w_clear         = 1'b1;
        next_r.st       = (r.def_slot == SPS_FACTORY_SLOT) ? SPS_APP_A
                                                           : SPS_VER_A;
      end
      SPS_IDLE: begin
        next_r.boot = 1'b0;
        if (req.valid && r.ready && !hit) begin
          next_r.resp.valid = 1'b1;
          next_r.resp.rdata = '0;
        end else if (acc_rd) begin
          next_r.resp.valid = 1'b1;
          next_r.resp.rdata = ctrl_word;
        end else if (acc_wr) begin
          next_r.fault = SPS_F_NONE;
          next_r.slot  = w_slot;
          next_r.acc   = '0;
          w_clear      = 1'b1;
          if (!(f_save || f_rest || f_def)) begin
            next_r.resp.valid = 1'b1;
          end else if (!PRESENT) begin
            next_r.fault      = SPS_F_ABSENT;
            next_r.resp.valid = 1'b1;
          end else if (f_save) begin
            if (w_slot == SPS_FACTORY_SLOT || !in_range) begin
              next_r.fault      = SPS_F_RANGE;
              next_r.resp.valid = 1'b1;
            end else begin
              next_r.capture_off = 1'b1;
              next_r.src_slot    = w_slot;
              next_r.st          = SPS_SAVE;
            end
          end else if (f_rest) begin
            if (!camera_idle) begin
              next_r.fault      = SPS_F_NOT_IDLE;
              next_r.resp.valid = 1'b1;
            end else if (!in_range || !r.slot_ok[w_slot]) begin
              next_r.fault       = SPS_F_NO_SLOT;
              next_r.factory_all = 1'b1;
              next_r.slot        = SPS_FACTORY_SLOT;
              next_r.src_slot    = SPS_FACTORY_SLOT;
              next_r.st          = SPS_APP_A;
            end else begin
              next_r.src_slot = w_slot;
              next_r.st = (w_slot == SPS_FACTORY_SLOT) ? SPS_APP_A
                                                       : SPS_VER_A;
            end
          end else begin
            if (in_range && r.slot_ok[w_slot]) begin
              next_r.def_slot = w_slot;
            end else begin
              next_r.fault = SPS_F_NO_SLOT;
            end
            next_r.resp.valid = 1'b1;
          end
          next_r.resp.rdata = ctrl_word;
        end else if (init_command) begin
          next_r.st = SPS_BOOT;
        end
      end
      SPS_SAVE: begin
        // live settings word at cfg.addr, checksum word at the end
        m_wr       = 1'b1;
        m_wdata    = w_last ? r.acc : cfg_rdata;
        next_r.acc = r.acc ^ cfg_rdata;
        w_step     = !w_last;
        if (w_last) begin
          next_r.slot_ok[r.src_slot] = 1'b1;
          next_r.fault = lut_fault ? SPS_F_LUT_STORE : r.fault;
          next_r.st    = SPS_IDLE;
          next_r.resp.valid = 1'b1;
        end
      end
      SPS_VER_A: begin
        next_r.st = SPS_VER_D;
      end
      SPS_VER_D: begin
        next_r.acc = r.acc ^ m_rdata;
        if (!w_last) begin
          w_step    = 1'b1;
          next_r.st = SPS_VER_A;
        end else begin
          w_clear = 1'b1;
          next_r.st = SPS_APP_A;
          if ((r.acc ^ m_rdata) != '0) begin
            next_r.fault = r.boot ? SPS_F_DEF_FAIL : SPS_F_CORRUPT;
            next_r.factory_all = 1'b1;
            next_r.slot        = SPS_FACTORY_SLOT;
            next_r.src_slot    = SPS_FACTORY_SLOT;
          end
        end
      end
      SPS_APP_A: begin
        next_r.st = SPS_APP_D;
      end
      SPS_APP_D: begin
        if (!w_last) begin
          next_r.cfg.wr    = 1'b1;
          next_r.cfg.wdata = m_rdata;
          next_r.st        = SPS_APP_W;
        end else begin
          if (lut_fault && r.fault == SPS_F_NONE) begin
            next_r.fault = SPS_F_LUT_LOAD;
          end
          next_r.st         = SPS_IDLE;
          next_r.resp.valid = !r.boot;
        end
      end
      SPS_APP_W: begin
        w_step    = 1'b1;
        next_r.st = SPS_APP_A;
      end
      default: begin
        next_r.st = SPS_BOOT;
      end
    endcase
    if (next_r.resp.valid && r.st != SPS_IDLE) begin
      next_r.resp.rdata = ctrl_word;
    end
    next_r.cfg.addr = SPS_CFG_AW'(w_clear ? '0 : w_idx + IW'(w_step));
    next_r.busy  = next_r.st != SPS_IDLE;
    next_r.ready = next_r.st == SPS_IDLE && !init_command;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      r          <= '0;
      r.st       <= SPS_BOOT;
      r.def_slot <= SPS_RST_DEF_SLOT;
      r.slot_ok  <= 16'h0001;
      r.busy     <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------
  // walker and slot storage
  // ------------------------------------------------------------
  sps_walker #(.COUNT(STEPS)) u_walk (
    .clk   (clk),
    .rstn  (rstn),
    .clear (w_clear),
    .step  (w_step),
    .idx   (w_idx),
    .last  (w_last)
  );

  sps_slot_mem #(
    .SLOTS (NUM_SLOTS),
    .WORDS (STEPS),
    .WIDTH (SPS_DATA_W)
  ) u_mem (
    .clk     (clk),
    .wr_en   (m_wr),
    .wr_slot (r.src_slot),
    .wr_idx  (w_idx),
    .wdata   (m_wdata),
    .rd_slot (r.src_slot),
    .rd_idx  (w_idx),
    .rdata   (m_rdata)
  );

  // memory channel registers are never touched from here
  assign req_ready   = r.ready;
  assign resp        = r.resp;
  assign cfg         = r.cfg;
  assign capture_off = r.capture_off;
  assign factory_all = r.factory_all;
  assign busy        = r.busy;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_slot0_kept: assert property (@(posedge clk) disable iff (!rstn)
    m_wr |-> r.src_slot != SPS_FACTORY_SLOT)
    else $error("factory slot written");
  chk_one_op: assert property (@(posedge clk) disable iff (!rstn)
    (r.st != SPS_IDLE) |-> (r.busy && !r.ready))
    else $error("busy or ready wrong during operation");
  chk_late_resp: assert property (@(posedge clk) disable iff (!rstn)
    (acc_wr && PRESENT && f_rest && camera_idle && in_range
     && r.slot_ok[w_slot] && w_slot != SPS_FACTORY_SLOT)
    |=> !r.resp.valid [*2])
    else $error("restore answered early");
  chk_fault_clr: assert property (@(posedge clk) disable iff (!rstn)
    (acc_wr && !f_save && !f_rest && !f_def)
    |=> r.fault == SPS_F_NONE && r.resp.valid && r.st == SPS_IDLE)
    else $error("plain write did not clear fault");
  chk_err_flag: assert property (@(posedge clk) disable iff (!rstn)
    r.resp.valid |-> r.resp.rdata[30] == (r.resp.rdata[11:8] != 4'h0))
    else $error("error flag mismatch");
  chk_capture: assert property (@(posedge clk) disable iff (!rstn)
    (acc_wr && PRESENT && f_save && in_range && w_slot != 4'h0)
    |=> r.capture_off && r.st == SPS_SAVE)
    else $error("save did not stop capture");
  chk_not_idle: assert property (@(posedge clk) disable iff (!rstn)
    (acc_wr && PRESENT && !f_save && f_rest && !camera_idle)
    |=> r.fault == SPS_F_NOT_IDLE && r.resp.valid)
    else $error("not idle code missing");
  chk_factory: assert property (@(posedge clk) disable iff (!rstn)
    r.factory_all |-> (r.slot == 4'h0 && r.src_slot == 4'h0
                       && r.fault != 4'h0))
    else $error("factory load without slot zero");
  chk_cfg_wr: assert property (@(posedge clk) disable iff (!rstn)
    r.cfg.wr |-> (r.st == SPS_APP_W && $past(r.st) == SPS_APP_D))
    else $error("settings written outside restore");
  chk_boot_quiet: assert property (@(posedge clk) disable iff (!rstn)
    (r.boot && r.st != SPS_IDLE) |-> !r.resp.valid)
    else $error("response during startup load");

  cov_save: cover property (@(posedge clk) disable iff (!rstn)
    r.st == SPS_SAVE && w_last);
  cov_restore: cover property (@(posedge clk) disable iff (!rstn)
    r.st == SPS_APP_D && w_last && !r.boot);
  cov_factory: cover property (@(posedge clk) disable iff (!rstn)
    r.factory_all);
endmodule // sps_profile_ctrl
`default_nettype wire

// file: sim/sps_live_settings.sv
`timescale 1ns/10ps
`default_nettype none
module sps_live_settings (
  input  wire logic              clk,
  input  wire sps_pkg::sps_cfg_t cfg,
  output logic [31:0]            cfg_rdata
);
  import sps_pkg::*;

  // ------------------------------------------------------------
  // live settings array
  // ------------------------------------------------------------
  logic [31:0] mem [0:255];

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 32'hFFFF_FF00 ^ i;
    end
  end

  // answered in the same cycle as the index
  assign cfg_rdata = mem[cfg.addr];

  always @(posedge clk) begin
    if (cfg.wr === 1'b1) begin
      mem[cfg.addr] <= cfg.wdata;
    end
  end
endmodule // sps_live_settings
`default_nettype wire

// file: sim/settings_profile_store_test.sv
`timescale 1ns/10ps
`default_nettype none
module settings_profile_store_test;
  import sps_pkg::*;

  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam logic [31:0] A      = SPS_CTRL_OFFSET;
  localparam logic [31:0] F_SAVE = 32'h0080_0000;
  localparam logic [31:0] F_REST = 32'h0040_0000;
  localparam logic [31:0] F_SDEF = 32'h0020_0000;
  localparam logic [31:0] MASK   = 32'hC000_0F00;
  logic        clk;
  logic        rstn;
  sps_req_t    req;
  logic        req_ready;
  sps_resp_t   resp;
  sps_cfg_t    cfg;
  logic [31:0] cfg_rdata;
  logic        init_command;
  logic        camera_idle;
  logic        lut_fault;
  logic        capture_off;
  logic        factory_all;
  logic        busy;
  logic        seen_cap;
  logic        seen_fac;
  logic        seen_busy;
  logic [31:0] rd;
  int          lat;
  int          n_errors;
  int          n_checks;

  // slot count and word count fixed by parameters: 4 slots of 16 words
  sps_profile_ctrl #(.NUM_SLOTS(4), .NUM_WORDS(16), .PRESENT(1'b1)) uut (
    .clk(clk), .rstn(rstn), .req(req), .req_ready(req_ready),
    .resp(resp), .cfg(cfg), .cfg_rdata(cfg_rdata),
    .init_command(init_command), .camera_idle(camera_idle),
    .lut_fault(lut_fault), .capture_off(capture_off),
    .factory_all(factory_all), .busy(busy)
  );

  sps_live_settings live (.clk(clk), .cfg(cfg), .cfg_rdata(cfg_rdata));

  initial clk = 1'b0;
  always #50 clk = ~clk;

  // pulses remembered until the next access has seen ready
  always @(posedge clk) begin
    if (capture_off === 1'b1) seen_cap <= 1'b1;
    if (factory_all === 1'b1) seen_fac <= 1'b1;
    if (busy === 1'b1) seen_busy <= 1'b1;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [31:0] word(input logic [3:0] f,
                                       input logic [3:0] s);
    word = 32'h8000_0000 | ({28'h0, f} << 8) | {28'h0, s};
    if (f != 4'h0) word = word | 32'h4000_0000;
  endfunction

  task automatic access(input logic wr, input logic [31:0] addr,
                        input logic [31:0] wd);
    int n;
    @(negedge clk);
    req = '{1'b1, wr, addr, wd};
    n = 0;
    while (req_ready !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    // pulses of this access only, not of the wait for ready
    seen_cap = 1'b0;
    seen_fac = 1'b0;
    seen_busy = 1'b0;
    @(posedge clk);
    @(negedge clk);
    req.valid = 1'b0;
    lat = 1;
    while (resp.valid !== 1'b1 && lat < 5000) begin
      @(negedge clk);
      lat++;
    end
    rd = resp.rdata;
    chk("answer in time", {31'h0, n >= 5000 || lat >= 5000}, 32'h0);
  endtask

  task automatic rdf(input string name, input logic [3:0] f);
    access(1'b0, A, 32'h0);
    chk(name, rd & MASK, word(f, 4'h0) & MASK);
  endtask

  task automatic results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #(40000 * 100);
    n_errors++;
    results();
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    req = '0;
    init_command = 1'b0;
    camera_idle = 1'b1;
    lut_fault = 1'b0;
    seen_cap = 1'b0;
    seen_fac = 1'b0;
    seen_busy = 1'b0;
    rd = 32'h0;
    lat = 0;
    n_errors = 0;
    n_checks = 0;
    repeat (20) @(negedge clk);
    chk("busy in reset", {31'h0, busy}, 32'h1);
    rstn = 1'b1;
    access(1'b0, A, 32'h0);
    chk("reset word", rd, word(SPS_F_NONE, SPS_FACTORY_SLOT));
    chk("read no busy", {31'h0, seen_busy}, 32'h0);
    access(1'b0, A + 32'h4, 32'h0);
    chk("unmapped read", rd, 32'h0);
    $display("test reset done");

    access(1'b1, A, F_SAVE);
    rdf("save slot 0", SPS_F_RANGE);
    access(1'b1, A, 32'h0000_0003);
    rdf("no flag clears", SPS_F_NONE);
    access(1'b1, A, F_SAVE | 32'h9);
    rdf("save slot 9", SPS_F_RANGE);
    access(1'b1, A, 32'h0);
    rdf("zero write clears", SPS_F_NONE);
    $display("test refusals done");

    for (int i = 0; i < 32; i++) live.mem[i] = 32'h1000_0000 + i;
    access(1'b1, A, F_SAVE | 32'h1);
    chk("capture off", {31'h0, seen_cap}, 32'h1);
    chk("busy in save", {31'h0, seen_busy}, 32'h1);
    chk("late answer", {31'h0, lat > 16}, 32'h1);
    rdf("save ok", SPS_F_NONE);
    for (int i = 0; i < 32; i++) live.mem[i] = 32'hDEAD_0000 + i;
    access(1'b1, A, F_REST | 32'h1);
    chk("restore late", {31'h0, lat > 16}, 32'h1);
    rdf("restore ok", SPS_F_NONE);
    for (int i = 0; i < 16; i++) begin
      chk("restored word", live.mem[i], 32'h1000_0000 + i);
    end
    chk("other word kept", live.mem[20], 32'hDEAD_0014);
    $display("test save restore done");

    camera_idle = 1'b0;
    access(1'b1, A, F_REST | 32'h1);
    camera_idle = 1'b1;
    rdf("not idle", SPS_F_NOT_IDLE);
    access(1'b1, A, F_REST | 32'h3);
    chk("factory pulse", {31'h0, seen_fac}, 32'h1);
    access(1'b0, A, 32'h0);
    chk("missing slot", rd, word(SPS_F_NO_SLOT, 4'h0));
    chk("factory word", live.mem[5], 32'h0000_0005);
    $display("test restore faults done");

    access(1'b1, A, F_SDEF | 32'h1);
    rdf("set default", SPS_F_NONE);
    for (int i = 0; i < 16; i++) live.mem[i] = 32'h0;
    init_command = 1'b1;
    @(negedge clk);
    init_command = 1'b0;
    repeat (2) @(negedge clk);
    access(1'b0, A, 32'h0);
    chk("init slot", rd, word(SPS_F_NONE, 4'h1));
    chk("init loaded", live.mem[3], 32'h1000_0003);
    $display("test default done");

    lut_fault = 1'b1;
    access(1'b1, A, F_SAVE | 32'h2);
    rdf("table store", SPS_F_LUT_STORE);
    access(1'b1, A, F_REST | 32'h1);
    lut_fault = 1'b0;
    rdf("table load", SPS_F_LUT_LOAD);
    $display("test table faults done");
    results();
  end
endmodule // settings_profile_store_test
`default_nettype wire
